// ==== tsa_pkg.sv ====
// shared constants for the two-wire status/control slave
package tsa_pkg;
   localparam int          TSA_BYTE_BITS    = 8;
   localparam int          TSA_BIT_CNT_W    = 4;
   localparam logic [3:0]  TSA_ACK_BIT      = 4'h8;   // ninth clock pulse index
   localparam logic [4:0]  TSA_ADDR_FIXED   = 5'h02;  // upper five chip address bits
   localparam logic [7:0]  TSA_REG_ADDR     = 8'h00;  // the only register address
   localparam logic [7:0]  TSA_CTRL_RESET   = 8'h00;
   localparam int          TSA_FIFO_DEPTH   = 32;
   localparam int          TSA_FIFO_WIDTH   = 8;
   typedef enum logic [2:0] {
      TSA_IDLE,
      TSA_CHIP,
      TSA_REGADR,
      TSA_WDATA,
      TSA_RDATA,
      TSA_IGNORE
   } tsa_state_type;
endpackage

// ==== tsa_fifo.sv ====
// small synchronous fifo carrying written control bytes
`timescale 1ns/1ps
module tsa_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             ce_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             do_wr;
   logic             do_rd;

   // full when pointers differ only in the wrap bit
   assign in_ready_out  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid_out = wr_ptr != rd_ptr;
   assign do_wr         = ce_in && in_valid_in && in_ready_out;
   assign do_rd         = ce_in && out_valid_out && out_ready_in;

   // pointer next values
   always_comb
   begin
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   // storage has no reset; data output registered from head entry
   always_ff @(posedge clk_in)
   begin
      if (do_wr)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         out_data_out <= '0;
      end
      else if (ce_in)
      begin
         // a word written into the head slot passes straight through,
         // so the data already stands in the cycle valid rises
         if (do_wr && wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0])
         begin
            out_data_out <= in_data_in;
         end
         else
         begin
            out_data_out <= mem[next_rd_ptr[AW-1:0]];
         end
      end
   end
endmodule

// ==== tsa_slave.sv ====
// two-wire serial slave: one control register in, one status register out
`timescale 1ns/1ps
module tsa_slave
   import tsa_pkg::*;
#(
   parameter int FIFO_DEPTH = TSA_FIFO_DEPTH
)
(
   // clock, reset, enable
   input  wire logic       SYS_CLK_IN,
   input  wire logic       RSTN_IN,
   input  wire logic       CE_IN,
   // serial bus pins
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_OUT,
   // address select pins
   input  wire logic [1:0] ADDR_SEL_IN,
   // fault inputs and latched status
   input  wire logic [7:0] FAULT_IN,
   output logic [7:0]      STATUS_OUT,
   output logic            IRQ_N_OUT,
   output logic            IRQ_N_OE_OUT,
   // written control bytes
   output logic            CTRL_VALID_OUT,
   input  wire logic       CTRL_READY_IN,
   output logic [7:0]      CTRL_DATA_OUT
);
   // synchronisers: first stage read only by second
   logic [1:0]          scl_sync;
   logic [1:0]          sda_sync;
   logic [1:0]          adr_s1;
   logic [1:0]          adr_s2;
   logic [7:0]          flt_s1;
   logic [7:0]          flt_s2;
   logic                scl_d;
   logic                sda_d;
   logic [1:0]          next_scl_sync;
   logic [1:0]          next_sda_sync;
   logic [1:0]          next_adr_s1;
   logic [1:0]          next_adr_s2;
   logic [7:0]          next_flt_s1;
   logic [7:0]          next_flt_s2;
   logic                next_scl_d;
   logic                next_sda_d;
   // protocol state
   tsa_state_type       state;
   tsa_state_type       next_state;
   logic [3:0]          bit_cnt;
   logic [3:0]          next_bit_cnt;
   logic [7:0]          shreg;
   logic [7:0]          next_shreg;
   logic                ack_en;
   logic                next_ack_en;
   logic                rd_dir;
   logic                next_rd_dir;
   logic                drive_low;
   logic                next_drive_low;
   logic [7:0]          status;
   logic [7:0]          next_status;
   logic                fifo_push;
   logic                fifo_ready;
   logic                status_clear;
   // bus events
   logic                scl_rise;
   logic                scl_fall;
   logic                start_cond;
   logic                stop_cond;
   logic                byte_done;
   logic [6:0]          my_addr;

   // next values of the synchronisers and of the edge history
   always_comb
   begin
      next_scl_sync = {scl_sync[0], SCL_IN};
      next_sda_sync = {sda_sync[0], SDA_IN};
      next_adr_s1   = ADDR_SEL_IN;
      next_adr_s2   = adr_s1;
      next_flt_s1   = FAULT_IN;
      next_flt_s2   = flt_s1;
      next_scl_d    = scl_sync[1];
      next_sda_d    = sda_sync[1];
   end

   // reset to the idle bus level so no false edge follows reset
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         adr_s1   <= 2'h0;
         adr_s2   <= 2'h0;
         flt_s1   <= 8'h00;
         flt_s2   <= 8'h00;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end
      else if (CE_IN)
      begin
         scl_sync <= next_scl_sync;
         sda_sync <= next_sda_sync;
         adr_s1   <= next_adr_s1;
         adr_s2   <= next_adr_s2;
         flt_s1   <= next_flt_s1;
         flt_s2   <= next_flt_s2;
         scl_d    <= next_scl_d;
         sda_d    <= next_sda_d;
      end
   end

   // edges of the sampled clock; start/stop are data edges while clock is high
   assign scl_rise   = scl_sync[1] && !scl_d;
   assign scl_fall   = !scl_sync[1] && scl_d;
   assign start_cond = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
   assign stop_cond  = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
   assign my_addr    = {TSA_ADDR_FIXED, adr_s2};
   assign byte_done  = (bit_cnt == TSA_ACK_BIT);

   // protocol sequencer, advances only on sampled serial clock edges and start/stop conditions
   always_comb
   begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shreg     = shreg;
      next_ack_en    = ack_en;
      next_rd_dir    = rd_dir;
      next_drive_low = drive_low;
      status_clear   = 1'b0;
      fifo_push      = 1'b0;
      if (start_cond || stop_cond)
      begin
         // abandon whatever byte was in flight
         next_state     = start_cond ? TSA_CHIP : TSA_IDLE;
         next_bit_cnt   = 4'h0;
         next_ack_en    = 1'b0;
         next_drive_low = 1'b0;
      end
      else if (scl_rise)
      begin
         if (!byte_done && state != TSA_RDATA)
         begin
            next_shreg   = {shreg[6:0], sda_sync[1]};
         end
         if (byte_done && state == TSA_RDATA)
         begin
            // master acknowledge low releases latched faults
            if (!sda_sync[1])
            begin
               status_clear = 1'b1;
            end
            else
            begin
               next_state = TSA_IGNORE;                               // nak ends read
            end
         end
         if (!byte_done)
         begin
            next_bit_cnt = bit_cnt + 4'h1;
         end
      end
      else if (scl_fall && state != TSA_IDLE && state != TSA_IGNORE)
      begin
         next_drive_low = 1'b0;
         if (byte_done && !ack_en)
         begin
            // eighth bit in: open the ninth pulse, acknowledge if good
            next_ack_en = 1'b0;
            case (state)
               TSA_CHIP:
               begin
                  next_ack_en = (shreg[7:1] == my_addr);
                  next_rd_dir = shreg[0];
               end
               TSA_REGADR:
                  next_ack_en = (shreg == TSA_REG_ADDR);
               TSA_WDATA:
                  next_ack_en = fifo_ready;                           // full fifo: nak
               default:
                  next_ack_en = 1'b1;                                 // read: slot is the master's
            endcase
            // hold low the whole pulse; on a read leave the line to the master
            next_drive_low = next_ack_en && state != TSA_RDATA;
            if (!next_ack_en)
            begin
               next_state = TSA_IGNORE;
            end
            else if (state == TSA_WDATA)
            begin
               fifo_push = 1'b1;
            end
         end
         else if (byte_done)
         begin
            // ninth pulse over: move to next byte
            next_ack_en  = 1'b0;
            next_bit_cnt = 4'h0;
            case (state)
               TSA_CHIP:   next_state = rd_dir ? TSA_RDATA : TSA_REGADR;
               TSA_REGADR: next_state = TSA_WDATA;
               TSA_WDATA:  next_state = TSA_IGNORE;                   // single register
               default:    next_state = TSA_IGNORE;                 // one status byte per read
            endcase
            if (state == TSA_CHIP && rd_dir)
            begin
               next_shreg     = status;
               next_drive_low = !status[7];                           // first status bit
            end
         end
         else if (state == TSA_RDATA && !byte_done)
         begin
            // shift out status msb first, changed only on falling clock
            next_shreg     = {shreg[6:0], 1'b0};
            next_drive_low = !shreg[6];
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         state     <= TSA_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         ack_en    <= 1'b0;
         rd_dir    <= 1'b0;
         drive_low <= 1'b0;
      end
      else if (CE_IN)
      begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         shreg     <= next_shreg;
         ack_en    <= next_ack_en;
         rd_dir    <= next_rd_dir;
         drive_low <= next_drive_low;
      end
   end

   // fault latch: every active fault sets its bit; a master acknowledge
   // reloads from the live faults, so a fault still present survives
   // the clear (set wins over clear)
   always_comb
   begin
      if (status_clear)
      begin
         next_status = flt_s2;
      end
      else
      begin
         next_status = status | flt_s2;
      end
   end

   // status kept apart from the sequencer so only the acknowledge clears it
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         status <= 8'h00;
      end
      else if (CE_IN)
      begin
         status <= next_status;
      end
   end

   // open-drain: only ever pull low, never drive high
   assign SDA_OUT      = 1'b0;
   assign SDA_OE_OUT   = drive_low;
   assign STATUS_OUT   = status;
   assign IRQ_N_OUT    = 1'b0;
   assign IRQ_N_OE_OUT = |status;

   // control bytes queue here; a full queue refuses the byte with a nak
   tsa_fifo #(
      .WIDTH (TSA_FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in        (SYS_CLK_IN),
      .rstn_in       (RSTN_IN),
      .ce_in         (CE_IN),
      .in_valid_in   (fifo_push),
      .in_ready_out  (fifo_ready),
      .in_data_in    (shreg),
      .out_valid_out (CTRL_VALID_OUT),
      .out_ready_in  (CTRL_READY_IN),
      .out_data_out  (CTRL_DATA_OUT)
   );
endmodule

// ==== tsa_slave_properties.sv ====
// port checks for the two-wire slave
`timescale 1ns/1ps
module tsa_slave_properties
(
   // clock, reset and serial pins
   input wire logic       SYS_CLK_IN,
   input wire logic       RSTN_IN,
   input wire logic       CE_IN,
   input wire logic       SCL_IN,
   input wire logic       SDA_IN,
   input wire logic       SDA_OUT,
   input wire logic       SDA_OE_OUT,
   // faults, status and control bytes
   input wire logic [7:0] FAULT_IN,
   input wire logic [7:0] STATUS_OUT,
   input wire logic       IRQ_N_OUT,
   input wire logic       IRQ_N_OE_OUT,
   input wire logic       CTRL_VALID_OUT,
   input wire logic       CTRL_READY_IN,
   input wire logic [7:0] CTRL_DATA_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // a raised fault still missing from status after the sync delay;
   // counted only while enabled, since a low enable freezes the latch
   sequence fault_missed;
      (CE_IN && (FAULT_IN & ~STATUS_OUT) != 8'h00) [*6];
   endsequence
   chk_sda_pull_only: assert property (SDA_OUT == 1'b0)
      else $error("data pin driven high");
   chk_oe_clock_low: assert property ($changed(SDA_OE_OUT) |-> !$past(SCL_IN, 2))
      else $error("data drive moved near clock high");
   chk_oe_bus_rest: assert property (SCL_IN [*8] |-> !SDA_OE_OUT)
      else $error("data held while clock rests");
   chk_fault_latch: assert property (not fault_missed)
      else $error("fault not latched");
   chk_irq_on_status: assert property ($rose(|STATUS_OUT) |-> ##[0:2] IRQ_N_OE_OUT)
      else $error("irq not raised");
   chk_irq_release: assert property ((STATUS_OUT == 8'h00) [*3] |-> !IRQ_N_OE_OUT)
      else $error("irq held without status");
   chk_irq_pull_only: assert property (IRQ_N_OUT == 1'b0)
      else $error("interrupt pin driven high");
   chk_status_on_ack: assert property (|($past(STATUS_OUT) & ~STATUS_OUT) |->
      !$past(SDA_IN, 2))
      else $error("status released without master ack");
   chk_ctrl_hold: assert property (CTRL_VALID_OUT && !CTRL_READY_IN |=>
      CTRL_VALID_OUT && $stable(CTRL_DATA_OUT))
      else $error("control byte lost");
endmodule
bind tsa_slave tsa_slave_properties chk
(
   .SYS_CLK_IN     (SYS_CLK_IN),
   .RSTN_IN        (RSTN_IN),
   .CE_IN          (CE_IN),
   .SCL_IN         (SCL_IN),
   .SDA_IN         (SDA_IN),
   .SDA_OUT        (SDA_OUT),
   .SDA_OE_OUT     (SDA_OE_OUT),
   .FAULT_IN       (FAULT_IN),
   .STATUS_OUT     (STATUS_OUT),
   .IRQ_N_OUT      (IRQ_N_OUT),
   .IRQ_N_OE_OUT   (IRQ_N_OE_OUT),
   .CTRL_VALID_OUT (CTRL_VALID_OUT),
   .CTRL_READY_IN  (CTRL_READY_IN),
   .CTRL_DATA_OUT  (CTRL_DATA_OUT)
);

// ==== tsa_master_model.sv ====
// behavioural two-wire bus master facing the slave
`timescale 1ns/1ps
module tsa_master_model
(
   // time base and wired data level
   input  wire logic clk,
   input  wire logic sda,
   // serial clock and data pull-down enable
   output logic      scl,
   output logic      sda_oe
);
   // only this side makes the clock; it rests high with both lines free
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // every change lands just after a clock edge
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // data moves mid low phase, sampled at end of high phase
   task automatic bit_x(input logic b, output logic r);
      w(2);
      sda_oe = ~b;
      w(2);
      scl = 1'b1;
      w(4);
      r = sda;
      scl = 1'b0;
   endtask
   // s high: start (also repeated); s low: stop, clock left resting
   task automatic cond(input logic s);
      w(2);
      sda_oe = !s;
      w(2);
      scl = 1'b1;
      w(4);
      sda_oe = s;
      w(4);
      scl = !s;
   endtask
   // eight bits then the answer slot; ak low acknowledges a status byte
   task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(tx[i], r);
         rx[i] = r;
      end
      bit_x(ak, ack);
   endtask
endmodule

// ==== tsa_slave_bench.sv ====
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
`define CHK(a, b, m) cmp((a) !== (b), m)
module tsa_slave_bench;
   import tsa_pkg::*;
   // clock, reset and pins
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       ce = 1'b1;
   logic       scl;
   logic       moe;
   logic       oe;
   wire        sda = !(moe || oe);
   logic [1:0] sel = 2'h1;
   logic [7:0] fault = 8'h00;
   logic [7:0] status;
   logic       irq_oe;
   logic       valid;
   logic       ready = 1'b0;
   logic [7:0] data;
   logic [6:0] chip;
   logic [2:0] acks;
   logic [7:0] st;
   int         num_errors = 0;
   int         n_compared = 0;
   assign chip = {TSA_ADDR_FIXED, sel};
   // slave and master share the wired data line
   tsa_slave uut
   (
      .SYS_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(), .SDA_OE_OUT(oe), .ADDR_SEL_IN(sel), .FAULT_IN(fault), .STATUS_OUT(status),
      .IRQ_N_OUT(), .IRQ_N_OE_OUT(irq_oe), .CTRL_VALID_OUT(valid), .CTRL_READY_IN(ready),
      .CTRL_DATA_OUT(data)
   );
   tsa_master_model mst (.clk(clk), .sda(sda), .scl(scl), .sda_oe(moe));
   always #25 clk = ~clk;
   task automatic cmp(input logic bad, input string m);
      n_compared++;
      if (bad)
      begin
         num_errors++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task automatic print_verdict();
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // write: chip address, register address, data byte
   task automatic wr(input logic [6:0] ca, input logic [7:0] ra, input logic [7:0] d);
      logic [7:0] rx;
      mst.cond(1'b1);
      mst.xfer({ca, 1'b0}, 1'b1, rx, acks[2]);
      mst.xfer(ra, 1'b1, rx, acks[1]);
      mst.xfer(d, 1'b1, rx, acks[0]);
      mst.cond(1'b0);
   endtask
   // read: address phase, stop, repeated address, status byte
   task automatic rd(input logic ak);
      logic [7:0] rx;
      mst.cond(1'b1);
      mst.xfer({chip, 1'b0}, 1'b1, rx, acks[2]);
      mst.xfer(TSA_REG_ADDR, 1'b1, rx, acks[1]);
      mst.cond(1'b0);
      mst.cond(1'b1);
      mst.xfer({chip, 1'b1}, 1'b1, rx, acks[0]);
      mst.xfer(8'hff, ak, st, rx[0]);
      mst.cond(1'b0);
   endtask
   task automatic pop(input logic [7:0] d);
      `CHK({valid, data}, {1'b1, d}, "control byte");
      ready = 1'b1;
      mst.w(1);
      ready = 1'b0;
   endtask
   // each select value, with the neighbouring address refused
   task automatic t_sel();
      for (int s = 0; s < 4; s++)
      begin
         sel = 2'(s);
         mst.w(4);
         wr({TSA_ADDR_FIXED, 2'(s + 1)}, TSA_REG_ADDR, 8'h33);
         `CHK(acks, 3'b111, "foreign address");
         wr(chip, TSA_REG_ADDR, 8'ha0 + 8'(s));
         `CHK(acks, 3'b000, "write acks");
         pop(8'ha0 + 8'(s));
         `CHK(valid, 1'b0, "extra byte");
      end
   endtask
   task automatic t_reg();
      for (int i = 0; i < 8; i += 7)
      begin
         wr(chip, 8'h01 << i, 8'h77);
         `CHK({acks, valid}, 4'b0110, "bad register");
      end
   endtask
   // partial address cut by a start, then by a stop
   task automatic t_abort();
      logic r;
      for (int k = 0; k < 2; k++)
      begin
         mst.cond(1'b1);
         for (int i = 0; i < 4; i++)
            mst.bit_x(1'b0, r);
         if (k == 1)
            mst.cond(1'b0);
         wr(chip, TSA_REG_ADDR, 8'hc3 ^ 8'(k));
         `CHK(acks, 3'b000, "after abort");
         pop(8'hc3 ^ 8'(k));
      end
   endtask
   // consumer stalls until the fifo refuses, then drains in order
   task automatic t_fifo();
      for (int i = 0; i <= TSA_FIFO_DEPTH; i++)
      begin
         wr(chip, TSA_REG_ADDR, 8'(i));
         `CHK(acks, (i < TSA_FIFO_DEPTH) ? 3'b000 : 3'b001, "fill acks");
      end
      for (int i = 0; i < TSA_FIFO_DEPTH; i++)
         pop(8'(i));
      `CHK(valid, 1'b0, "not drained");
   endtask
   task automatic t_read();
      fault = 8'h05;
      mst.w(8);
      `CHK({status, irq_oe}, {8'h05, 1'b1}, "latch");
      fault = 8'h00;
      rd(1'b1);
      `CHK({acks, st, status}, {3'b000, 8'h05, 8'h05}, "nak read");
      fault = 8'h02;
      rd(1'b0);
      `CHK({acks, st, status, irq_oe}, {3'b000, 8'h07, 8'h02, 1'b1}, "held");
      fault = 8'h00;
      rd(1'b0);
      `CHK({st, status, irq_oe}, {8'h02, 8'h00, 1'b0}, "release");
   endtask
   // enable low freezes the fault latch, which catches up once enabled
   task automatic t_ce();
      ce = 1'b0;
      fault = 8'h10;
      mst.w(8);
      `CHK({status, irq_oe}, {8'h00, 1'b0}, "frozen");
      ce = 1'b1;
      mst.w(8);
      `CHK({status, irq_oe}, {8'h10, 1'b1}, "thawed");
      fault = 8'h00;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      #1;
      rstn = 1'b1;
      mst.w(4);
      t_sel();
      t_reg();
      t_abort();
      t_fifo();
      t_read();
      t_ce();
      print_verdict();
   end
   // a hang is cut short and counted
   initial
   begin
      repeat (100000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule
